/* File: design/led_ramp_pkg.sv */
// led_ramp_pkg: register map, field layout, reset values and ramp timing
// assumes a 20 MHz system clock shared by every design file that imports it
package led_ramp_pkg;

  // clock and timing units
  localparam int CLK_PERIOD_NS = 50;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int CODE_STEPS = 127; // full code range 0x00..0x7f

  // full-scale ramp times in milliseconds, codes 001..111 (000 is instant)
  localparam int RAMP_MS_1 = 128;
  localparam int RAMP_MS_2 = 256;
  localparam int RAMP_MS_3 = 512;
  localparam int RAMP_MS_4 = 760;
  localparam int RAMP_MS_5 = 1000;
  localparam int RAMP_MS_6 = 2000;
  localparam int RAMP_MS_7 = 4000;

  // register pointers on the serial bus
  localparam logic [7:0] PTR_CHANNEL1_CURRENT_LEVEL_RAMP = 8'h0b;
  localparam logic [7:0] PTR_LED2_RAMP = 8'h0c;
  localparam logic [7:0] PTR_CH1_LEVEL = 8'h0d;

  // reset values
  localparam logic [7:0] RST_CHANNEL1_CURRENT_LEVEL_RAMP = 8'h80;
  localparam logic [7:0] RST_LED2_RAMP = 8'h00;
  localparam logic [7:0] RST_CH1_LEVEL = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // field layout
  localparam int TIME_W = 3;
  localparam int CODE_W = 7;
  localparam int VIB_W = 2;
  localparam int RISE_LSB = 0;
  localparam int FALL_LSB = 3;
  localparam int VIB_LSB = 6;
  localparam int CH1_RAMP_EN_BIT = 6;
  localparam int CH2_RAMP_EN_BIT = 7;
  localparam int CODE_LSB = 0;
  localparam int CUR_EN_BIT = 7;

  // vibrator limit encodings
  localparam logic [1:0] VIB_SEL_1V3 = 2'h0;
  localparam logic [1:0] VIB_SEL_2V5 = 2'h1;
  localparam logic [1:0] VIB_SEL_3V0 = 2'h2;
  localparam logic [1:0] VIB_SEL_BYPASS = 2'h3;

  // 7-bit bus address, value is arbitrary
  localparam logic [6:0] BUS_ADDR = 7'h3c;

  typedef enum logic [3:0] {
    st_idle, st_addr, st_addr_ack, st_ptr, st_ptr_ack,
    st_wdata, st_wdata_ack, st_rdata, st_rdata_ack
  } bus_state_t;

  // full-scale time of a ramp code in ms, zero means no ramp
  function automatic int ramp_ms(input logic [2:0] code);
    case (code)
      3'h1: ramp_ms = RAMP_MS_1;
      3'h2: ramp_ms = RAMP_MS_2;
      3'h3: ramp_ms = RAMP_MS_3;
      3'h4: ramp_ms = RAMP_MS_4;
      3'h5: ramp_ms = RAMP_MS_5;
      3'h6: ramp_ms = RAMP_MS_6;
      3'h7: ramp_ms = RAMP_MS_7;
      default: ramp_ms = 0;
    endcase
  endfunction : ramp_ms

endpackage : led_ramp_pkg

/* File: design/ramp_stepper.sv */
// ramp_stepper: walks a 7-bit current code toward its target one code at a time, or jumps there when ramping is off or the time code is zero
// assumes target and time selects come straight from registers on the same clock
`timescale 1ns/1ns
module ramp_stepper #(
  parameter int CYCLES_PER_MS = led_ramp_pkg::CYCLES_PER_MS
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [6:0] target, // requested current code
  input wire logic ramp_en, // ramping allowed for this channel
  input wire logic [2:0] rise_sel, // full-scale ramp-up time code
  input wire logic [2:0] fall_sel, // full-scale ramp-down time code
  output logic [6:0] level_q // code applied to the regulator
);

  logic [6:0] level_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic rising;
  logic [2:0] sel;
  logic [31:0] step_cycles;

  // per-step interval is full-scale time over 127 codes, rounded down, at least one
  always_comb begin
    rising = (target > level_q);
    sel = rising ? rise_sel : fall_sel;
    step_cycles = 32'((led_ramp_pkg::ramp_ms(sel) * CYCLES_PER_MS) / led_ramp_pkg::CODE_STEPS);
    if (step_cycles == 32'h0) begin
      step_cycles = 32'h1;
    end
  end

  // next code: jump when ramping is off or time code is zero, else one step per interval
  always_comb begin
    level_d = level_q;
    cnt_d = cnt_q;
    if (!ramp_en || sel == 3'h0) begin
      level_d = target;
      cnt_d = 32'h0;
    end else if (target == level_q) begin
      cnt_d = 32'h0;
    end else if (cnt_q >= step_cycles - 32'h1) begin
      cnt_d = 32'h0;
      level_d = rising ? 7'(level_q + 7'h1) : 7'(level_q - 7'h1);
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= 7'h00;
      cnt_q <= 32'h0;
    end else begin
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : ramp_stepper

/* File: design/led_dimming_ramp_control.sv */
// led_dimming_ramp_control: serial-bus register bank for led ramps and vibrator limit
// assumes scl and sda inputs already synchronous to clk; sda is open drain outside
// What this block does
// - Channel 1 ramp-up time is the 3-bit field in bits 2:0 of the first ramp register, 0s to 4s, reset 000.
// - Channel 1 ramp-down time is the 3-bit field in bits 5:3 of the first ramp register, same codes, reset 000.
// - Channel 2 ramp-up time is bits 2:0 of the second ramp register with the same eight codes.
// - Channel 2 ramp-down time is bits 5:3 of the second ramp register, same codes, reset 000.
// - Bits 7:6 of the first ramp register pick the vibrator limit 1.3V, 2.5V, 3.0V or bypass, reset 10.
// - Channel 1 ramps only while bit 6 of the second ramp register is set, reset clear.
// - Channel 2 ramps only while bit 7 of the second ramp register is set, reset clear.
`timescale 1ns/1ns
module led_dimming_ramp_control #(
  parameter int CYCLES_PER_MS = led_ramp_pkg::CYCLES_PER_MS
) (
  input wire logic clk, // system clock, 20 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic scl_in, // serial clock from host
  input wire logic sda_in, // serial data level on the wire
  output logic sda_out, // data driven when enabled, always low
  output logic sda_oe, // high while pulling sda low
  input wire logic [6:0] ch2_target_code, // channel 2 current code from its own register
  output logic [6:0] ch1_current_code, // ramped channel 1 code
  output logic ch1_regulator_on, // channel 1 regulator enable
  output logic [6:0] ch2_current_code, // ramped channel 2 code
  output logic [1:0] vibrator_max_output_select, // vibrator limit code
  output logic [2:0] ch1_rise_time, // channel 1 ramp-up code
  output logic [2:0] ch1_fall_time, // channel 1 ramp-down code
  output logic [2:0] ch2_rise_time, // channel 2 ramp-up code
  output logic [2:0] ch2_fall_time, // channel 2 ramp-down code
  output logic ch1_ramp_enable, // channel 1 ramp allowed
  output logic ch2_ramp_enable // channel 2 ramp allowed
);

  led_ramp_pkg::bus_state_t state_q, state_d;
  logic scl_q, sda_q;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic rw_q, rw_d;
  logic oe_q, oe_d;
  logic phase_q, phase_d; // second half of an acknowledge slot
  logic mack_q, mack_d; // host asked for another read byte
  logic [7:0] ramp1_q, ramp1_d;
  logic [7:0] ramp2_q, ramp2_d;
  logic [7:0] level_q, level_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] rx_byte;
  logic [7:0] rd_data;

  // bus edges; start and stop are sda moving while scl stays high
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
  assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;
  assign rx_byte = {shift_q[6:0], sda_in};

  // read mux; unmapped pointers answer zero rather than floating
  always_comb begin
    case (ptr_q)
      led_ramp_pkg::PTR_CHANNEL1_CURRENT_LEVEL_RAMP: rd_data = ramp1_q;
      led_ramp_pkg::PTR_LED2_RAMP: rd_data = ramp2_q;
      led_ramp_pkg::PTR_CH1_LEVEL: rd_data = level_q;
      default: rd_data = led_ramp_pkg::UNMAPPED_READ;
    endcase
  end

  // bus state machine and register writes
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    oe_d = oe_q;
    phase_d = phase_q;
    mack_d = mack_q;
    ramp1_d = ramp1_q;
    ramp2_d = ramp2_q;
    level_d = level_q;
    if (bus_stop) begin
      state_d = led_ramp_pkg::st_idle;
      oe_d = 1'b0;
    end else if (bus_start) begin
      // a repeated start keeps the pointer so a read can follow a pointer write
      state_d = led_ramp_pkg::st_addr;
      bit_cnt_d = 3'h0;
      oe_d = 1'b0;
      phase_d = 1'b0;
    end else begin
      case (state_q)
        led_ramp_pkg::st_idle: begin
          oe_d = 1'b0;
        end
        led_ramp_pkg::st_addr, led_ramp_pkg::st_ptr, led_ramp_pkg::st_wdata: begin
          if (scl_rise) begin
            shift_d = rx_byte;
            bit_cnt_d = 3'(bit_cnt_q + 3'h1);
            if (bit_cnt_q == 3'h7) begin
              phase_d = 1'b0;
              case (state_q)
                led_ramp_pkg::st_addr: begin
                  state_d = led_ramp_pkg::st_addr_ack;
                  rw_d = rx_byte[0];
                end
                led_ramp_pkg::st_ptr: begin
                  state_d = led_ramp_pkg::st_ptr_ack;
                  ptr_d = rx_byte;
                end
                default: begin
                  state_d = led_ramp_pkg::st_wdata_ack;
                  case (ptr_q)
                    led_ramp_pkg::PTR_CHANNEL1_CURRENT_LEVEL_RAMP: ramp1_d = rx_byte;
                    led_ramp_pkg::PTR_LED2_RAMP: ramp2_d = rx_byte;
                    led_ramp_pkg::PTR_CH1_LEVEL: level_d = rx_byte;
                    default: ;
                  endcase
                  ptr_d = 8'(ptr_q + 8'h1);
                end
              endcase
            end
          end
        end
        led_ramp_pkg::st_addr_ack, led_ramp_pkg::st_ptr_ack, led_ramp_pkg::st_wdata_ack: begin
          if (scl_fall && !phase_q) begin
            // only our own address is acknowledged; others drop the bus quietly
            if (state_q == led_ramp_pkg::st_addr_ack && shift_q[7:1] != led_ramp_pkg::BUS_ADDR) begin
              state_d = led_ramp_pkg::st_idle;
            end else begin
              oe_d = 1'b1;
              phase_d = 1'b1;
            end
          end else if (scl_fall) begin
            phase_d = 1'b0;
            bit_cnt_d = 3'h0;
            if (state_q == led_ramp_pkg::st_addr_ack && rw_q) begin
              state_d = led_ramp_pkg::st_rdata;
              shift_d = rd_data;
              oe_d = ~rd_data[7];
            end else begin
              oe_d = 1'b0;
              state_d = (state_q == led_ramp_pkg::st_addr_ack) ? led_ramp_pkg::st_ptr : led_ramp_pkg::st_wdata;
            end
          end
        end
        led_ramp_pkg::st_rdata: begin
          if (scl_rise) begin
            bit_cnt_d = 3'(bit_cnt_q + 3'h1);
            if (bit_cnt_q == 3'h7) begin
              state_d = led_ramp_pkg::st_rdata_ack;
              phase_d = 1'b0;
            end
          end else if (scl_fall) begin
            shift_d = {shift_q[6:0], 1'b0};
            oe_d = ~shift_q[6];
          end
        end
        led_ramp_pkg::st_rdata_ack: begin
          if (scl_fall && !phase_q) begin
            oe_d = 1'b0; // release for the host acknowledge
          end else if (scl_rise) begin
            phase_d = 1'b1;
            mack_d = ~sda_in;
            if (!sda_in) begin
              ptr_d = 8'(ptr_q + 8'h1);
            end
          end else if (scl_fall) begin
            phase_d = 1'b0;
            bit_cnt_d = 3'h0;
            if (mack_q) begin
              state_d = led_ramp_pkg::st_rdata;
              shift_d = rd_data;
              oe_d = ~rd_data[7];
            end else begin
              state_d = led_ramp_pkg::st_idle;
            end
          end
        end
        default: begin
          state_d = led_ramp_pkg::st_idle;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= led_ramp_pkg::st_idle;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      phase_q <= 1'b0;
      mack_q <= 1'b0;
      ramp1_q <= led_ramp_pkg::RST_CHANNEL1_CURRENT_LEVEL_RAMP;
      ramp2_q <= led_ramp_pkg::RST_LED2_RAMP;
      level_q <= led_ramp_pkg::RST_CH1_LEVEL;
    end else begin
      state_q <= state_d;
      scl_q <= scl_in;
      sda_q <= sda_in;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      phase_q <= phase_d;
      mack_q <= mack_d;
      ramp1_q <= ramp1_d;
      ramp2_q <= ramp2_d;
      level_q <= level_d;
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  // field decode straight from the stored bytes
  assign ch1_rise_time = ramp1_q[led_ramp_pkg::RISE_LSB +: led_ramp_pkg::TIME_W];
  assign ch1_fall_time = ramp1_q[led_ramp_pkg::FALL_LSB +: led_ramp_pkg::TIME_W];
  assign vibrator_max_output_select = ramp1_q[led_ramp_pkg::VIB_LSB +: led_ramp_pkg::VIB_W];
  assign ch2_rise_time = ramp2_q[led_ramp_pkg::RISE_LSB +: led_ramp_pkg::TIME_W];
  assign ch2_fall_time = ramp2_q[led_ramp_pkg::FALL_LSB +: led_ramp_pkg::TIME_W];
  assign ch1_ramp_enable = ramp2_q[led_ramp_pkg::CH1_RAMP_EN_BIT];
  assign ch2_ramp_enable = ramp2_q[led_ramp_pkg::CH2_RAMP_EN_BIT];
  assign ch1_regulator_on = level_q[led_ramp_pkg::CUR_EN_BIT];

  // channel 1 target follows its current register
  ramp_stepper #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_ch1 (
    .clk(clk),
    .rst(rst),
    .target(level_q[led_ramp_pkg::CODE_LSB +: led_ramp_pkg::CODE_W]),
    .ramp_en(ch1_ramp_enable),
    .rise_sel(ch1_rise_time),
    .fall_sel(ch1_fall_time),
    .level_q(ch1_current_code)
  );

  // channel 2 target comes from outside this bank
  ramp_stepper #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_ch2 (
    .clk(clk),
    .rst(rst),
    .target(ch2_target_code),
    .ramp_en(ch2_ramp_enable),
    .rise_sel(ch2_rise_time),
    .fall_sel(ch2_fall_time),
    .level_q(ch2_current_code)
  );

endmodule : led_dimming_ramp_control

/* File: sim/led_ramp_sva.sv */
// led_ramp_sva: port-level checks of the ramp register bank
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module led_ramp_sva #(
  parameter int CYCLES_PER_MS = 127
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic scl_in, // bus clock
  input wire logic sda_out, // data level
  input wire logic sda_oe, // pull enable
  input wire logic [6:0] ch2_target_code, // ch2 target
  input wire logic [6:0] ch1_current_code, // ch1 code
  input wire logic ch1_regulator_on, // ch1 on
  input wire logic [6:0] ch2_current_code, // ch2 code
  input wire logic [1:0] vibrator_max_output_select, // vib limit
  input wire logic [2:0] ch1_rise_time, // ch1 up
  input wire logic [2:0] ch1_fall_time, // ch1 down
  input wire logic [2:0] ch2_rise_time, // ch2 up
  input wire logic [2:0] ch2_fall_time, // ch2 down
  input wire logic ch1_ramp_enable, // ch1 ramp
  input wire logic ch2_ramp_enable // ch2 ramp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic ch1_slow;
  // both times set, so the stepper may move at most one code a clock
  assign ch1_slow = ch1_ramp_enable && (ch1_rise_time != 3'h0) && (ch1_fall_time != 3'h0);
  // reset values seen at the first edge after release
  vib_reset_a: assert property ($fell(rst) |-> vibrator_max_output_select == 2'h2)
    else $error("vibrator limit not 10 after reset");
  ch1_time_reset_a: assert property ($fell(rst) |-> {ch1_fall_time, ch1_rise_time} == 6'h00)
    else $error("ch1 ramp times not zero after reset");
  ch2_time_reset_a: assert property ($fell(rst) |-> {ch2_fall_time, ch2_rise_time} == 6'h00)
    else $error("ch2 ramp times not zero after reset");
  ramp_en_reset_a: assert property ($fell(rst) |-> !ch1_ramp_enable && !ch2_ramp_enable)
    else $error("ramp enables set after reset");
  ch1_reset_a: assert property ($fell(rst) |-> ch1_current_code == 7'h00 && !ch1_regulator_on)
    else $error("ch1 code or regulator not cleared by reset");
  // behaviour in running operation
  ch2_follow_a: assert property (!ch2_ramp_enable |=> ch2_current_code == $past(ch2_target_code))
    else $error("ch2 code does not follow target without ramp");
  ch1_step_a: assert property (ch1_slow ##1 ch1_slow |-> (ch1_current_code == $past(ch1_current_code)) ||
    (ch1_current_code == $past(ch1_current_code) + 7'h01) || (ch1_current_code == $past(ch1_current_code) - 7'h01))
    else $error("ch1 code jumped more than one step while ramping");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed while scl high");
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("sda data level not low");
  cover property ($rose(sda_oe));
  cover property (ch1_slow && $changed(ch1_current_code));
  cover property ($changed(vibrator_max_output_select));
endmodule : led_ramp_sva

bind led_dimming_ramp_control led_ramp_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_sva (.clk(clk), .rst(rst),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .ch2_target_code(ch2_target_code),
  .ch1_current_code(ch1_current_code), .ch1_regulator_on(ch1_regulator_on), .ch2_current_code(ch2_current_code),
  .vibrator_max_output_select(vibrator_max_output_select), .ch1_rise_time(ch1_rise_time),
  .ch1_fall_time(ch1_fall_time), .ch2_rise_time(ch2_rise_time), .ch2_fall_time(ch2_fall_time),
  .ch1_ramp_enable(ch1_ramp_enable), .ch2_ramp_enable(ch2_ramp_enable));

/* File: sim/i2c_host_model.sv */
// i2c_host_model: serial bus master, drives scl and its share of sda
// assumes the bench resolves open-drain sda with a pull-up
`timescale 1ns/1ns
module i2c_host_model (
  input wire logic clk, // system clock
  input wire logic sda_wire, // resolved sda
  output logic scl, // bus clock, idles high
  output logic sda // 1 releases the line
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // four clocks a phase, above the three-clock minimum the slave needs
  task automatic ph();
    repeat (4) @(negedge clk);
  endtask : ph
  // start or repeated start, ends with scl low
  task automatic start();
    sda = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda = 1'b0;
    ph();
    scl = 1'b0;
    ph();
  endtask : start
  task automatic stop();
    sda = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda = 1'b1;
    ph();
  endtask : stop
  // sda only moves while scl is low, so no false start or stop
  task automatic put(input logic b);
    sda = b;
    ph();
    scl = 1'b1;
    ph();
    scl = 1'b0;
    ph();
  endtask : put
  task automatic get(output logic b);
    sda = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    b = sda_wire;
    scl = 1'b0;
    ph();
  endtask : get
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ack = !a;
  endtask : wbyte
  task automatic rbyte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(!more);
  endtask : rbyte
endmodule : i2c_host_model

/* File: sim/tb_top.sv */
// tb_top: drives the register bank over the serial bus and checks outputs
// assumes the design package and the host model are compiled first
`timescale 1ns/1ns
module tb_top;
  logic clk, rst, scl, host_sda, sda_oe, sda_out, sda_wire, reg_on, en1, en2, a;
  logic [6:0] ch2_target_code, ch1_code, ch2_code, t2;
  logic [1:0] vib;
  logic [2:0] r1, f1, r2, f2;
  logic [7:0] m [int];
  logic [7:0] d;
  int mismatches, n_checks;
  // open drain with pull-up: low if either side pulls
  assign sda_wire = host_sda & ~sda_oe;
  i2c_host_model host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda(host_sda));
  led_dimming_ramp_control #(.CYCLES_PER_MS(127)) DUT (.clk(clk), .rst(rst), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .ch2_target_code(ch2_target_code),
    .ch1_current_code(ch1_code), .ch1_regulator_on(reg_on), .ch2_current_code(ch2_code),
    .vibrator_max_output_select(vib), .ch1_rise_time(r1), .ch1_fall_time(f1), .ch2_rise_time(r2),
    .ch2_fall_time(f2), .ch1_ramp_enable(en1), .ch2_ramp_enable(en2));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_byte
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // unmapped pointers are dropped but still advance the pointer
  task automatic reg_write(input logic [7:0] p, input logic [7:0] q[$]);
    host.start();
    host.wbyte({led_ramp_pkg::BUS_ADDR, 1'b0}, a);
    host.wbyte(p, a);
    foreach (q[i]) begin
      host.wbyte(q[i], a);
      check_byte({7'h00, a}, 8'h01);
      if (m.exists(p)) m[p] = q[i];
      p++;
    end
    host.stop();
  endtask : reg_write
  task automatic reg_read(input logic [7:0] p, input int n);
    host.start();
    host.wbyte({led_ramp_pkg::BUS_ADDR, 1'b0}, a);
    host.wbyte(p, a);
    host.start();
    host.wbyte({led_ramp_pkg::BUS_ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      host.rbyte(i < n - 1, d);
      check_byte(d, m.exists(p) ? m[p] : 8'h00);
      p++;
    end
    host.stop();
  endtask : reg_read
  // field outputs against the register model
  task automatic check_outs();
    check_byte({2'h0, f1, r1}, {2'h0, m[11][5:0]});
    check_byte({6'h00, vib}, {6'h00, m[11][7:6]});
    check_byte({2'h0, f2, r2}, {2'h0, m[12][5:0]});
    check_byte({6'h00, en2, en1}, {6'h00, m[12][7:6]});
    check_byte({reg_on, ch1_code}, m[13]);
    // only called with channel 2 ramping off, so its code must match the target
    check_byte({1'b0, ch2_code}, {1'b0, ch2_target_code});
  endtask : check_outs
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  // main sequence: reset values, field sweep, refusals, then ramps
  initial begin
    rst = 1'b1;
    ch2_target_code = 7'h00;
    m[11] = 8'h80;
    m[12] = 8'h00;
    m[13] = 8'h00;
    void'($urandom(32'h39e4e7ef));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check_outs();
    reg_read(8'h0b, 3);
    for (int i = 0; i < 4; i++) begin
      ch2_target_code = 7'($urandom);
      reg_write(8'h0b, '{{2'(i), 6'($urandom)}, 8'($urandom) & 8'h3f, 8'($urandom)});
      check_outs();
      reg_read(8'h0b, 3);
    end
    reg_write(8'h0e, '{8'h5a});
    reg_read(8'h0d, 2);
    host.start();
    host.wbyte({led_ramp_pkg::BUS_ADDR ^ 7'h01, 1'b0}, a);
    host.stop();
    check_byte({7'h00, a}, 8'h00);
    // ch1 ramps: up 128 clocks a code, down 256 clocks a code
    reg_write(8'h0d, '{8'h00});
    reg_write(8'h0b, '{8'h91, 8'hc9});
    reg_write(8'h0d, '{8'h83});
    // ch2 ramps one code either way, 128 clocks a code in both directions
    t2 = ch2_target_code;
    ch2_target_code = t2 ^ 7'h01;
    check_byte({1'b0, ch1_code}, 8'h00);
    check_byte({1'b0, ch2_code}, {1'b0, t2});
    repeat (200) @(negedge clk);
    check_byte({1'b0, ch1_code}, 8'h01);
    check_byte({1'b0, ch2_code}, {1'b0, ch2_target_code});
    repeat (300) @(negedge clk);
    check_byte({reg_on, ch1_code}, 8'h83);
    reg_write(8'h0d, '{8'h00});
    repeat (200) @(negedge clk);
    check_byte({1'b0, ch1_code}, 8'h03);
    repeat (300) @(negedge clk);
    check_byte({1'b0, ch1_code}, 8'h01);
    give_verdict();
  end
endmodule : tb_top
